// File: hcrv_regs.vh
// Reset values and field layout of the host controller register fields.
// Assumes inclusion by the reset-value bank, its checker and its testbench.
`ifndef HCRV_REGS_VH
`define HCRV_REGS_VH

// Bus management fields
`define HCRV_BM_ID_W 6
`define HCRV_BM_ID_RST 6'h3f
`define HCRV_BW_W 13
`define HCRV_BW_RST 13'h1333
`define HCRV_CH_RST 32'hffff_ffff

// Configuration ROM header fields
`define HCRV_INFO_LEN_LSB 24
`define HCRV_CRC_LEN_LSB 16
`define HCRV_CRC_VAL_LSB 0
`define HCRV_LEN_RST 8'h00
`define HCRV_CRC_RST 16'h0000

// Unique identifier fields
`define HCRV_VENDOR_LSB 8
`define HCRV_SERIAL_HI_LSB 0
`define HCRV_VENDOR_RST 24'h00_0000
`define HCRV_SERIAL_HI_RST 8'h00
`define HCRV_SERIAL_LO_RST 32'h0000_0000

// Bus options fields, largest supported values
`define HCRV_MAX_REC_LSB 12
`define HCRV_MAX_REC_W 4
`define HCRV_MAX_REC_RST 4'ha
`define HCRV_LINK_SPD_LSB 0
`define HCRV_LINK_SPD_W 3
`define HCRV_LINK_SPD_RST 3'h2

// Controller control bits
`define HCRV_LINK_ON_BIT 17
`define HCRV_LPS_BIT 19
`define HCRV_CTL_BIT_RST 1'b0

`endif

// File: hcrv_pin_sync.v
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous level input and the block clock i_clk.
`timescale 1ns/100ps

module hcrv_pin_sync (
  input wire i_clk,    // Block clock
  input wire i_rst_b,  // Synchronous reset, active low
  input wire i_pin,    // Raw pin level
  output reg o_level   // Filtered level
);

  reg meta_ff;
  reg s2_ff;
  reg s3_ff;

  ////////////////////////////////////////////////////////////////
  // Shift chain; level changes once stages two and three agree
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      meta_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      o_level <= 1'b0;
    end else begin
      meta_ff <= i_pin;
      s2_ff <= meta_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        o_level <= s3_ff;
      end
    end
  end

endmodule // hcrv_pin_sync

// File: hcrv_reset_bank.v
// Host controller register fields with per-cause reset loading.
// Assumes register decode elsewhere drives write strobes and data on i_clk;
// the bus reset arrives as a level from the link, outside the clock domain.
//
// Contract
// - Three reset causes; each field either loads its own value or holds, per cause.
// - Bus reset leaves fields alone unless a bus value exists.
// - Bus manager id loads 3f on hardware and bus reset.
// - Bandwidth loads 1333 hex on hardware and bus reset.
// - Both channel masks load all ones on hardware and bus reset.
// - Hardware reset clears ROM header lengths and CRC; soft keeps lengths.
// - Hardware reset clears vendor and serial fields; soft reset keeps them.
// - Link on and power status bits clear on hardware and soft reset.
// - Hardware reset loads max receive and link speed maxima; soft keeps receive.
`timescale 1ns/100ps
`include "hcrv_regs.vh"

module hcrv_reset_bank (
  input wire i_clk,            // 10 MHz block clock
  input wire i_rst_b,          // Hardware reset, active low
  input wire i_soft_reset,     // Software reset pulse
  input wire i_bus_reset_pin,  // Bus reset level from the link
  input wire [31:0] i_wr_data, // Write data for all strobes
  input wire i_wr_bm_id,       // Write bus manager id
  input wire i_wr_bw,          // Write available bandwidth
  input wire i_wr_ch_hi,       // Write upper channel mask
  input wire i_wr_ch_lo,       // Write lower channel mask
  input wire i_wr_rom_hdr,     // Write config ROM header
  input wire i_wr_uid_hi,      // Write unique id upper word
  input wire i_wr_uid_lo,      // Write unique id lower word
  input wire i_wr_bus_opt,     // Write serial bus options
  input wire i_wr_ctl,         // Write controller control
  output reg [5:0] o_bus_manager_id,       // Bus manager id
  output reg [12:0] o_bandwidth_avail,     // Available bandwidth
  output reg [31:0] o_channels_avail_hi,   // Upper channel mask
  output reg [31:0] o_channels_avail_lo,   // Lower channel mask
  output reg [7:0] o_rom_info_length,      // ROM header info length
  output reg [7:0] o_rom_crc_length,       // ROM header CRC length
  output reg [15:0] o_rom_crc_value,       // ROM header CRC value
  output reg [23:0] o_node_vendor,         // Node vendor field
  output reg [7:0] o_part_serial_upper,    // Upper serial field
  output reg [31:0] o_part_serial_lower,   // Lower serial field
  output reg [3:0] o_max_receive,          // Max receive size code
  output reg [2:0] o_link_speed,           // Link speed code
  output reg o_link_on_bit,                // Link enable
  output reg o_link_power_status_bit,      // Link power status
  output reg o_bus_reset_event             // Bus reset taken, one pulse
);

  wire bus_level;
  reg bus_level_ff;
  wire bus_reset;
  wire wr_ok;
  reg [5:0] nxt_bus_manager_id;
  reg [12:0] nxt_bandwidth_avail;
  reg [31:0] nxt_channels_avail_hi;
  reg [31:0] nxt_channels_avail_lo;
  reg [7:0] nxt_rom_info_length;
  reg [7:0] nxt_rom_crc_length;
  reg [15:0] nxt_rom_crc_value;
  reg [23:0] nxt_node_vendor;
  reg [7:0] nxt_part_serial_upper;
  reg [31:0] nxt_part_serial_lower;
  reg [3:0] nxt_max_receive;
  reg [2:0] nxt_link_speed;
  reg nxt_link_on_bit;
  reg nxt_link_power_status_bit;

  ////////////////////////////////////////////////////////////////
  // Bus reset pin crossing and rising-edge event
  hcrv_pin_sync hcrv_pin_sync_i (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_pin(i_bus_reset_pin),
    .o_level(bus_level)
  );

  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      bus_level_ff <= 1'b0;
    end else begin
      bus_level_ff <= bus_level;
    end
  end

  assign bus_reset = bus_level & ~bus_level_ff;

  // Event pulse for the rest of the link logic
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_bus_reset_event <= 1'b0;
    end else begin
      o_bus_reset_event <= bus_reset;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Writes are refused in every cycle that soft reset is high
  assign wr_ok = ~i_soft_reset;

  ////////////////////////////////////////////////////////////////
  // Bus management fields: hardware and bus reset load, soft reset holds
  // Next values; soft reset leaves them undefined, holding is one legal value
  always @* begin
    nxt_bus_manager_id = o_bus_manager_id;
    nxt_bandwidth_avail = o_bandwidth_avail;
    nxt_channels_avail_hi = o_channels_avail_hi;
    nxt_channels_avail_lo = o_channels_avail_lo;
    if (bus_reset) begin
      nxt_bus_manager_id = `HCRV_BM_ID_RST;
      nxt_bandwidth_avail = `HCRV_BW_RST;
      nxt_channels_avail_hi = `HCRV_CH_RST;
      nxt_channels_avail_lo = `HCRV_CH_RST;
    end else if (wr_ok) begin
      if (i_wr_bm_id) begin
        nxt_bus_manager_id = i_wr_data[5:0];
      end
      if (i_wr_bw) begin
        nxt_bandwidth_avail = i_wr_data[12:0];
      end
      if (i_wr_ch_hi) begin
        nxt_channels_avail_hi = i_wr_data;
      end
      if (i_wr_ch_lo) begin
        nxt_channels_avail_lo = i_wr_data;
      end
    end
  end

  // Hardware reset wins over bus reset and writes
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_bus_manager_id <= `HCRV_BM_ID_RST;
      o_bandwidth_avail <= `HCRV_BW_RST;
      o_channels_avail_hi <= `HCRV_CH_RST;
      o_channels_avail_lo <= `HCRV_CH_RST;
    end else begin
      o_bus_manager_id <= nxt_bus_manager_id;
      o_bandwidth_avail <= nxt_bandwidth_avail;
      o_channels_avail_hi <= nxt_channels_avail_hi;
      o_channels_avail_lo <= nxt_channels_avail_lo;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Config ROM header: hardware reset only, bus reset has no value
  // Next values; bus reset is no term here, soft reset keeps the lengths
  always @* begin
    nxt_rom_info_length = o_rom_info_length;
    nxt_rom_crc_length = o_rom_crc_length;
    nxt_rom_crc_value = o_rom_crc_value;
    if (i_wr_rom_hdr && wr_ok) begin
      nxt_rom_info_length = i_wr_data[`HCRV_INFO_LEN_LSB+7:`HCRV_INFO_LEN_LSB];
      nxt_rom_crc_length = i_wr_data[`HCRV_CRC_LEN_LSB+7:`HCRV_CRC_LEN_LSB];
      nxt_rom_crc_value = i_wr_data[`HCRV_CRC_VAL_LSB+15:`HCRV_CRC_VAL_LSB];
    end
  end

  // Hardware reset clears lengths and CRC
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_rom_info_length <= `HCRV_LEN_RST;
      o_rom_crc_length <= `HCRV_LEN_RST;
      o_rom_crc_value <= `HCRV_CRC_RST;
    end else begin
      o_rom_info_length <= nxt_rom_info_length;
      o_rom_crc_length <= nxt_rom_crc_length;
      o_rom_crc_value <= nxt_rom_crc_value;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Unique identifier: cleared by hardware reset only
  // Next values; neither bus nor soft reset touches them
  always @* begin
    nxt_node_vendor = o_node_vendor;
    nxt_part_serial_upper = o_part_serial_upper;
    nxt_part_serial_lower = o_part_serial_lower;
    if (i_wr_uid_hi && wr_ok) begin
      nxt_node_vendor = i_wr_data[`HCRV_VENDOR_LSB+23:`HCRV_VENDOR_LSB];
      nxt_part_serial_upper = i_wr_data[`HCRV_SERIAL_HI_LSB+7:`HCRV_SERIAL_HI_LSB];
    end
    if (i_wr_uid_lo && wr_ok) begin
      nxt_part_serial_lower = i_wr_data;
    end
  end

  // Hardware reset clears vendor and serial fields
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_node_vendor <= `HCRV_VENDOR_RST;
      o_part_serial_upper <= `HCRV_SERIAL_HI_RST;
      o_part_serial_lower <= `HCRV_SERIAL_LO_RST;
    end else begin
      o_node_vendor <= nxt_node_vendor;
      o_part_serial_upper <= nxt_part_serial_upper;
      o_part_serial_lower <= nxt_part_serial_lower;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Bus options: maxima on hardware reset, link speed held on soft reset
  // Next values; bus reset has no value for these fields
  always @* begin
    nxt_max_receive = o_max_receive;
    nxt_link_speed = o_link_speed;
    if (i_wr_bus_opt && wr_ok) begin
      nxt_max_receive = i_wr_data[`HCRV_MAX_REC_LSB+`HCRV_MAX_REC_W-1:`HCRV_MAX_REC_LSB];
      nxt_link_speed = i_wr_data[`HCRV_LINK_SPD_LSB+`HCRV_LINK_SPD_W-1:`HCRV_LINK_SPD_LSB];
    end
  end

  // Hardware reset loads the supported maxima
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_max_receive <= `HCRV_MAX_REC_RST;
      o_link_speed <= `HCRV_LINK_SPD_RST;
    end else begin
      o_max_receive <= nxt_max_receive;
      o_link_speed <= nxt_link_speed;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Controller control bits: cleared by hardware and soft reset
  // Next values; soft reset clears, bus reset leaves them alone
  always @* begin
    nxt_link_on_bit = o_link_on_bit;
    nxt_link_power_status_bit = o_link_power_status_bit;
    if (i_soft_reset) begin
      nxt_link_on_bit = `HCRV_CTL_BIT_RST;
      nxt_link_power_status_bit = `HCRV_CTL_BIT_RST;
    end else if (i_wr_ctl) begin
      nxt_link_on_bit = i_wr_data[`HCRV_LINK_ON_BIT];
      nxt_link_power_status_bit = i_wr_data[`HCRV_LPS_BIT];
    end
  end

  // Hardware reset clears both bits
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_link_on_bit <= `HCRV_CTL_BIT_RST;
      o_link_power_status_bit <= `HCRV_CTL_BIT_RST;
    end else begin
      o_link_on_bit <= nxt_link_on_bit;
      o_link_power_status_bit <= nxt_link_power_status_bit;
    end
  end

endmodule // hcrv_reset_bank

// File: hcrv_monitor.sv
// Checker of per-cause reset loading in the register bank.
// Assumes a bind onto hcrv_reset_bank; sees its ports only.
`timescale 1ns/100ps
`include "hcrv_regs.vh"
module hcrv_monitor (
  input wire i_clk, // Clock
  input wire i_rst_b, // Hard reset
  input wire i_soft_reset, // Soft reset
  input wire [5:0] o_bus_manager_id, // Id
  input wire [12:0] o_bandwidth_avail, // Bandwidth
  input wire [31:0] o_channels_avail_hi, // Mask
  input wire [31:0] o_channels_avail_lo, // Mask
  input wire [7:0] o_rom_info_length, // Length
  input wire [23:0] o_node_vendor, // Vendor
  input wire [3:0] o_max_receive, // Size
  input wire o_link_on_bit, // Link on
  input wire o_link_power_status_bit, // Power
  input wire o_bus_reset_event // Pulse
);
  ////////////////////////////////////////
  // Reset values per cause
  default clocking @(posedge i_clk);
  endclocking
  a_hw_bm_id: assert property (!i_rst_b |=> o_bus_manager_id == 6'h3f)
    else $error("id not reset");
  a_hw_bw: assert property (!i_rst_b |=> o_bandwidth_avail == 13'h1333)
    else $error("bandwidth not reset");
  a_hw_chan: assert property (!i_rst_b |=> &{o_channels_avail_hi, o_channels_avail_lo})
    else $error("masks not reset");
  a_hw_rom_len: assert property (!i_rst_b |=> o_rom_info_length == 8'h00)
    else $error("length not cleared");
  a_hw_vendor_max: assert property (!i_rst_b |=> o_node_vendor == 24'h0 && o_max_receive == 4'ha)
    else $error("vendor or size wrong");
  a_soft_ctl: assert property (disable iff (!i_rst_b) i_soft_reset
    |=> !o_link_on_bit && !o_link_power_status_bit) else $error("control bits kept");
  a_soft_keep: assert property (disable iff (!i_rst_b) i_soft_reset
    |=> $stable({o_rom_info_length, o_node_vendor, o_max_receive})) else $error("field lost");
  a_bus_event: assert property (disable iff (!i_rst_b) o_bus_reset_event
    |-> o_bus_manager_id == 6'h3f && o_bandwidth_avail == 13'h1333 && &o_channels_avail_lo)
    else $error("bus fields not loaded");
endmodule // hcrv_monitor
bind hcrv_reset_bank hcrv_monitor hcrv_monitor_i (.*);

// File: hcrv_reset_bank_test.sv
// Bench for hard, soft and bus reset loading of the bank.
// Assumes the header, design and checker are compiled first.
`timescale 1ns/100ps
`include "hcrv_regs.vh"
module hcrv_reset_bank_test;
  reg i_clk = 0;
  reg i_rst_b = 0;
  reg i_soft_reset = 0;
  reg i_bus_reset_pin = 0;
  reg [31:0] i_wr_data = 0;
  reg [8:0] wr = 0;
  reg look = 0;
  wire [5:0] o_bus_manager_id;
  wire [12:0] o_bandwidth_avail;
  wire [31:0] o_channels_avail_hi, o_channels_avail_lo, o_part_serial_lower;
  wire [7:0] o_rom_info_length, o_rom_crc_length, o_part_serial_upper;
  wire [15:0] o_rom_crc_value;
  wire [23:0] o_node_vendor;
  wire [3:0] o_max_receive;
  wire [2:0] o_link_speed;
  wire o_link_on_bit, o_link_power_status_bit, o_bus_reset_event;
  reg [5:0] e_bm;
  reg [12:0] e_bw;
  reg [31:0] e_hi, e_lo, e_rom, e_uh, e_ul;
  reg [6:0] e_opt;
  reg e_on, e_lps;
  logic [187:0] q[$];
  int mismatches = 0;
  int n_checks = 0;
  int k;
  wire [187:0] obs = {o_bus_manager_id, o_bandwidth_avail, o_channels_avail_hi, o_channels_avail_lo,
    o_rom_info_length, o_rom_crc_length, o_rom_crc_value, o_node_vendor, o_part_serial_upper,
    o_part_serial_lower, o_max_receive, o_link_speed, o_link_on_bit, o_link_power_status_bit};
  hcrv_reset_bank hcrv_reset_bank_i (.i_wr_bm_id(wr[0]), .i_wr_bw(wr[1]), .i_wr_ch_hi(wr[2]),
    .i_wr_ch_lo(wr[3]), .i_wr_rom_hdr(wr[4]), .i_wr_uid_hi(wr[5]), .i_wr_uid_lo(wr[6]),
    .i_wr_bus_opt(wr[7]), .i_wr_ctl(wr[8]), .*);
  ////////////////////////////////////////
  // Clock
  initial forever #50 i_clk = ~i_clk;
  task ck(input [187:0] seen, input [187:0] want);
    n_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Note the model for the watcher
  task snap;
    // Build the note here, so a model update in this same step is seen
    q.push_back({e_bm, e_bw, e_hi, e_lo, e_rom, e_uh, e_ul, e_opt, e_on, e_lps});
    look = 1;
    @(posedge i_clk);
    #5 look = 0;
  endtask
  // Hard reset and its expected values
  task hw;
    i_rst_b = 0;
    repeat (3) @(posedge i_clk);
    #5 i_rst_b = 1;
    {e_bm, e_bw, e_hi, e_lo} = {6'h3f, 13'h1333, {64{1'b1}}};
    {e_rom, e_uh, e_ul, e_on, e_lps} = 98'h0;
    e_opt = {`HCRV_MAX_REC_RST, `HCRV_LINK_SPD_RST};
  endtask
  // One write strobe, model follows
  task w(input int n, input [31:0] v);
    i_wr_data = v;
    wr = 9'h001 << n;
    @(posedge i_clk);
    #5;
    case (n)
      0: e_bm = v[5:0];
      1: e_bw = v[12:0];
      2: e_hi = v;
      3: e_lo = v;
      4: e_rom = v;
      5: e_uh = v;
      6: e_ul = v;
      7: e_opt = {v[15:12], v[2:0]};
      default: {e_on, e_lps} = {v[17], v[19]};
    endcase
  endtask
  // Watcher compares the oldest note
  always @(negedge i_clk) begin
    if (look) begin
      ck(obs, q.pop_front());
    end
  end
  // Main sequence
  initial begin
    k = $urandom(76622);
    hw;
    snap;
    for (k = 0; k < 9; k++) w(k, $urandom);
    w(8, 32'h000a_0000);
    i_soft_reset = 1;
    wr = 9'h1ff;
    i_wr_data = $urandom;
    @(posedge i_clk);
    #5 i_soft_reset = 0;
    wr = 0;
    {e_on, e_lps} = 2'b00;
    snap;
    for (k = 0; k < 9; k++) w(k, $urandom);
    wr = 0;
    i_bus_reset_pin = 1;
    k = 0;
    while (o_bus_reset_event !== 1'b1 && k < 20) begin
      @(posedge i_clk);
      #5 k++;
    end
    mismatches += (k == 20);
    i_bus_reset_pin = 0;
    {e_bm, e_bw, e_hi, e_lo} = {6'h3f, 13'h1333, {64{1'b1}}};
    snap;
    hw;
    snap;
    stop_test;
  end
  // Watchdog
  initial begin
    #100000;
    mismatches++;
    stop_test;
  end
endmodule // hcrv_reset_bank_test
